// ===== shared/ict_defines.vh
// instruction timing constants: clocks, reads, writes per instruction group
// assumes a zero-wait-state bus of four clocks per cycle
`ifndef ICT_DEFINES_VH
`define ICT_DEFINES_VH
// operation codes on op_in
`define ICT_OP_W 5
`define ICT_OP_BIT_CHANGE 5'h00
`define ICT_OP_BIT_CLEAR 5'h01
`define ICT_OP_BIT_SET 5'h02
`define ICT_OP_BIT_TEST 5'h03
`define ICT_OP_BCOND 5'h04
`define ICT_OP_UNCOND_BRANCH 5'h05
`define ICT_OP_BRANCH_SUB 5'h06
`define ICT_OP_DEC_BRANCH 5'h07
`define ICT_OP_JUMP 5'h08
`define ICT_OP_JUMP_SUB 5'h09
`define ICT_OP_LOAD_ADDR 5'h0a
`define ICT_OP_PUSH_ADDR 5'h0b
`define ICT_OP_MULTI_M2R 5'h0c
`define ICT_OP_MULTI_R2M 5'h0d
`define ICT_OP_ALT_M2R 5'h0e
`define ICT_OP_ALT_R2M 5'h0f
`define ICT_OP_EXT_ADD 5'h10
`define ICT_OP_EXT_SUB 5'h11
`define ICT_OP_CMP_MEM 5'h12
`define ICT_OP_DEC_ADD 5'h13
`define ICT_OP_DEC_SUB 5'h14
// loop mode outcome
`define ICT_LOOP_NONE 2'h0
`define ICT_LOOP_CONT 2'h1
`define ICT_LOOP_TRUE 2'h2
`define ICT_LOOP_EXPIRED 2'h3
// field widths
`define ICT_CLK_W 8
`define ICT_CNT_W 6
`define ICT_N_W 5
// clocks per bus cycle without wait states
`define ICT_BUS_CLOCKS 8'h04
`define ICT_ONE 8'h01
`endif

// ===== hw/ict_timing.v
// instruction cycle timing: computes clocks and bus cycles per instruction,
// then counts the execution down. assumes op fields stable while start_in.
// Functional notes
// - result gives clocks, reads, writes; marked cases add address-calculation cost
// - dynamic memory bit ops: change/set 8, clear 10, test 4 clocks
// - register bit ops: 8/12, clear 10/14, test 6 dynamic clocks
// - branch taken 10; untaken byte 6, word 10; subroutine branch 18
// - decrement-branch: 10 clocks, or 16 with three reads on expiry with the condition false
// - indirect jump 8, jump-sub 16, load-address 4, push-address 12 clocks
// - multi-register alt_space_move_op scale with count n, long doubles per register
// - alternate-space alt_space_move_op take 18 clocks byte/word, 22 long
// - index register size never changes execution time
// - multiprecision figures are complete; no address-calculation cost is added
// - extended add/sub: 4/6 clocks registers, 18 or 30 memory
// - loop mode memory extended add/sub: 22, 28 or 26 clocks, long 32, 38 or 36
// - compare-memory 12 clocks, long 20, outside loop mode; decimal ops 6 register, 18 memory outside loop mode
`timescale 1ns/1ns
`include "ict_defines.vh"
module ict_timing (
	input wire clk_in,
	input wire rst_in,
	input wire start_in,
	input wire [4:0] op_in,
	input wire mem_in,
	input wire static_in,
	input wire long_in,
	input wire taken_in,
	input wire word_disp_in,
	input wire expired_in,
	input wire [1:0] loop_in,
	input wire [4:0] reg_count_in,
	input wire index_long_in,
	input wire [7:0] ea_clocks_in,
	input wire [5:0] ea_reads_in,
	input wire [5:0] ea_writes_in,
	input wire [7:0] wait_clocks_in,
	output reg [7:0] clocks_out,
	output reg [5:0] reads_out,
	output reg [5:0] writes_out,
	output reg busy_out,
	output reg done_out
);
	reg [7:0] base_clk;
	reg [5:0] base_rd;
	reg [5:0] base_wr;
	reg add_ea;
	reg [7:0] next_clocks;
	reg [7:0] remain;
	wire [7:0] n8 = {3'h0, reg_count_in};
	wire [5:0] n6 = {1'h0, reg_count_in};

	// choose byte/word figure or long figure
	function [7:0] sel;
		input l;
		input [7:0] a;
		input [7:0] b;
		begin
			sel = l ? b : a;
		end
	endfunction

	always @* begin
		base_clk = 8'h00;
		base_rd = 6'h00;
		base_wr = 6'h00;
		add_ea = 1'b0;
		case (op_in)
		`ICT_OP_BIT_CHANGE, `ICT_OP_BIT_SET, `ICT_OP_BIT_CLEAR: begin
			if (mem_in) begin
				base_clk = static_in ? 8'h0c : 8'h08;
				if (op_in == `ICT_OP_BIT_CLEAR)
					base_clk = base_clk + 8'h02;
				base_rd = static_in ? 6'h02 : 6'h01;
				base_wr = 6'h01;
				add_ea = 1'b1;
			end else begin
				base_clk = static_in ? 8'h0c : 8'h08;
				if (op_in == `ICT_OP_BIT_CLEAR)
					base_clk = base_clk + 8'h02;
				base_rd = static_in ? 6'h02 : 6'h01;
			end
		end
		`ICT_OP_BIT_TEST: begin
			if (mem_in) begin
				base_clk = static_in ? 8'h08 : 8'h04;
				base_rd = static_in ? 6'h02 : 6'h01;
				add_ea = 1'b1;
			end else begin
				base_clk = static_in ? 8'h0a : 8'h06;
				base_rd = static_in ? 6'h02 : 6'h01;
			end
		end
		`ICT_OP_BCOND, `ICT_OP_UNCOND_BRANCH: begin
			if (taken_in || op_in == `ICT_OP_UNCOND_BRANCH || word_disp_in) begin
				base_clk = 8'h0a;
				base_rd = 6'h02;
			end else begin
				base_clk = 8'h06;
				base_rd = 6'h01;
			end
		end
		`ICT_OP_BRANCH_SUB: begin
			base_clk = 8'h12;
			base_rd = 6'h02;
			base_wr = 6'h02;
		end
		`ICT_OP_DEC_BRANCH: begin
			// taken_in high means the condition is true
			if (!taken_in && expired_in) begin
				base_clk = 8'h10;
				base_rd = 6'h03;
			end else begin
				base_clk = 8'h0a;
				base_rd = 6'h02;
			end
		end
		`ICT_OP_JUMP: begin
			base_clk = 8'h08;
			base_rd = 6'h02;
		end
		`ICT_OP_JUMP_SUB: begin
			base_clk = 8'h10;
			base_rd = 6'h02;
			base_wr = 6'h02;
		end
		`ICT_OP_LOAD_ADDR: begin
			base_clk = 8'h04;
			base_rd = 6'h01;
		end
		`ICT_OP_PUSH_ADDR: begin
			base_clk = 8'h0c;
			base_rd = 6'h01;
			base_wr = 6'h02;
		end
		`ICT_OP_MULTI_M2R: begin
			// long indirect load form costs 24+8n, not 12+8n
			base_clk = long_in ? (8'h18 + (n8 << 3)) : (8'h0c + (n8 << 2));
			base_rd = long_in ? (6'h03 + (n6 << 1)) : (6'h03 + n6);
		end
		`ICT_OP_MULTI_R2M: begin
			base_clk = long_in ? (8'h08 + (n8 << 3)) : (8'h08 + (n8 << 2));
			base_rd = 6'h02;
			base_wr = long_in ? (n6 << 1) : n6;
		end
		`ICT_OP_ALT_M2R: begin
			base_clk = sel(long_in, 8'h12, 8'h16);
			base_rd = long_in ? 6'h04 : 6'h03;
		end
		`ICT_OP_ALT_R2M: begin
			base_clk = sel(long_in, 8'h12, 8'h16);
			base_rd = 6'h02;
			base_wr = long_in ? 6'h02 : 6'h01;
		end
		`ICT_OP_EXT_ADD, `ICT_OP_EXT_SUB: begin
			if (!mem_in) begin
				base_clk = sel(long_in, 8'h04, 8'h06);
				base_rd = 6'h01;
			end else begin
				case (loop_in)
				`ICT_LOOP_CONT: begin
					base_clk = sel(long_in, 8'h16, 8'h20);
					base_rd = long_in ? 6'h04 : 6'h02;
				end
				`ICT_LOOP_TRUE: begin
					base_clk = sel(long_in, 8'h1c, 8'h26);
					base_rd = long_in ? 6'h06 : 6'h04;
				end
				`ICT_LOOP_EXPIRED: begin
					base_clk = sel(long_in, 8'h1a, 8'h24);
					base_rd = long_in ? 6'h06 : 6'h04;
				end
				default: begin
					base_clk = sel(long_in, 8'h12, 8'h1e);
					base_rd = long_in ? 6'h05 : 6'h03;
				end
				endcase
				base_wr = long_in ? 6'h02 : 6'h01;
			end
		end
		`ICT_OP_CMP_MEM: begin
			// postincrement forms only; no write
			case (loop_in)
			`ICT_LOOP_CONT: begin
				base_clk = sel(long_in, 8'h0e, 8'h18);
				base_rd = long_in ? 6'h04 : 6'h02;
			end
			`ICT_LOOP_TRUE: begin
				base_clk = sel(long_in, 8'h14, 8'h1e);
				base_rd = long_in ? 6'h06 : 6'h04;
			end
			`ICT_LOOP_EXPIRED: begin
				base_clk = sel(long_in, 8'h12, 8'h1a);
				base_rd = long_in ? 6'h06 : 6'h04;
			end
			default: begin
				base_clk = sel(long_in, 8'h0c, 8'h14);
				base_rd = long_in ? 6'h05 : 6'h03;
			end
			endcase
		end
		`ICT_OP_DEC_ADD, `ICT_OP_DEC_SUB: begin
			if (!mem_in) begin
				base_clk = 8'h06;
				base_rd = 6'h01;
			end else begin
				case (loop_in)
				`ICT_LOOP_CONT: begin
					base_clk = 8'h18;
					base_rd = 6'h02;
				end
				`ICT_LOOP_TRUE: begin
					base_clk = 8'h1e;
					base_rd = 6'h04;
				end
				`ICT_LOOP_EXPIRED: begin
					base_clk = 8'h1c;
					base_rd = 6'h04;
				end
				default: begin
					base_clk = 8'h12;
					base_rd = 6'h03;
				end
				endcase
				base_wr = 6'h01;
			end
		end
		default: begin
			base_clk = 8'h00;
		end
		endcase
		// index_long_in is deliberately unused in every figure
		// multiprecision figures never take the address term
		next_clocks = base_clk + wait_clocks_in;
		if (add_ea)
			next_clocks = next_clocks + ea_clocks_in;
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			clocks_out <= 8'h00;
			reads_out <= 6'h00;
			writes_out <= 6'h00;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			remain <= 8'h00;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out && next_clocks != 8'h00) begin
				clocks_out <= next_clocks;
				reads_out <= add_ea ? base_rd + ea_reads_in : base_rd;
				writes_out <= add_ea ? base_wr + ea_writes_in : base_wr;
				remain <= next_clocks - `ICT_ONE;
				busy_out <= 1'b1;
			end else if (busy_out) begin
				if (remain == `ICT_ONE || remain == 8'h00) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
				remain <= remain - `ICT_ONE;
			end
		end
	end
endmodule

// ===== sim/ict_timing_asserts.sv
// concurrent checks on the ports of ict_timing, bound into every instance
// assumes ict_defines.vh on the include path and a zero-wait default bus
`timescale 1ns/1ns
`include "ict_defines.vh"
module ict_timing_chk (
	input wire clk_in,
	input wire rst_in,
	input wire start_in,
	input wire [4:0] op_in,
	input wire mem_in,
	input wire static_in,
	input wire long_in,
	input wire [4:0] reg_count_in,
	input wire [7:0] ea_clocks_in,
	input wire [7:0] wait_clocks_in,
	input wire [7:0] clocks_out,
	input wire [5:0] reads_out,
	input wire [5:0] writes_out,
	input wire busy_out,
	input wire done_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire acc = start_in && !busy_out;
	wire acc0 = acc && wait_clocks_in == 8'h00;
	reg [7:0] cnt;
	// busy cycles seen since the last accepted start
	always @(posedge clk_in) begin
		cnt <= busy_out ? cnt + 8'h01 : 8'h00;
	end
	jump_time_a: assert property (acc && op_in == `ICT_OP_JUMP |=> clocks_out == 8'h08 + $past(wait_clocks_in) && reads_out == 6'h02 && writes_out == 6'h00) else $error("jump timing off");
	push_addr_a: assert property (acc0 && op_in == `ICT_OP_PUSH_ADDR |=> clocks_out == 8'h0c && reads_out == 6'h01 && writes_out == 6'h02) else $error("push timing off");
	branch_sub_a: assert property (acc0 && op_in == `ICT_OP_BRANCH_SUB |=> clocks_out == 8'h12 && reads_out == 6'h02 && writes_out == 6'h02) else $error("branch sub timing off");
	multi_store_a: assert property (acc0 && op_in == `ICT_OP_MULTI_R2M && !long_in |=> clocks_out == 8'h08 + 8'h04 * $past(reg_count_in) && writes_out == {1'b0, $past(reg_count_in)}) else $error("multi store timing off");
	bit_mem_ea_a: assert property (acc0 && op_in == `ICT_OP_BIT_CLEAR && mem_in && !static_in |=> clocks_out == 8'h0a + $past(ea_clocks_in)) else $error("bit clear ea not added");
	done_pulse_a: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
	busy_len_a: assert property (done_out |-> !busy_out && cnt == clocks_out - 8'h01) else $error("busy length wrong");
	stand_a: assert property (busy_out |=> $stable(clocks_out) && $stable(reads_out) && $stable(writes_out)) else $error("counts changed while busy");
	reset_zero_a: assert property ($fell(rst_in) |-> !busy_out && !done_out && clocks_out == 8'h00) else $error("outputs not cleared by reset");
	cover property (acc && op_in == `ICT_OP_JUMP && wait_clocks_in != 8'h00);
	cover property (done_out && start_in ##1 busy_out);
	cover property (acc0 && op_in == `ICT_OP_MULTI_R2M);
endmodule
bind ict_timing ict_timing_chk chk_i (.*);

// ===== sim/ict_mem_model.sv
// system memory model: turns the bus cycles of an instruction into wait clocks
// assumes every bus cycle is stretched by the same number of wait states
`timescale 1ns/1ns
module ict_mem_model #(parameter [7:0] WAITS = 8'h02) (
	input wire [5:0] cycles_in,
	output wire [7:0] wait_clocks_out
);
	// the four base clocks per cycle are already in the figures
	assign wait_clocks_out = {2'h0, cycles_in} * WAITS;
endmodule

// ===== sim/tb.sv
// self-checking bench for ict_timing: table of timing rows, then edge cases
// assumes ict_defines.vh on the include path
`timescale 1ns/1ns
module tb;
	reg clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg start_in = 1'b0;
	reg [4:0] op_in = 5'h00;
	reg [5:0] fl = 6'h00;
	reg [1:0] loop_in = 2'h0;
	reg [4:0] reg_count_in = 5'h00;
	reg index_long_in = 1'b0;
	reg [7:0] ea_clocks_in = 8'h00;
	reg [5:0] ea_reads_in = 6'h00;
	reg [5:0] ea_writes_in = 6'h00;
	reg use_mem = 1'b0;
	reg [5:0] mem_cycles = 6'h00;
	wire [7:0] mem_wait;
	wire [7:0] clocks_out;
	wire [5:0] reads_out;
	wire [5:0] writes_out;
	wire busy_out;
	wire done_out;
	integer err_count = 0;
	integer compares = 0;
	integer cyc = 0;
	integer i;
	integer wk;
	// row: op, flags {mem,static,long,taken,word,expired}, loop, n, clocks, reads, writes
	reg [51:0] r [0:28];
	always #4 clk_in = ~clk_in;
	ict_mem_model #(.WAITS(8'h02)) mem (.cycles_in(mem_cycles), .wait_clocks_out(mem_wait));
	ict_timing DUT (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
		.mem_in(fl[5]), .static_in(fl[4]), .long_in(fl[3]), .taken_in(fl[2]),
		.word_disp_in(fl[1]), .expired_in(fl[0]), .loop_in(loop_in),
		.reg_count_in(reg_count_in), .index_long_in(index_long_in),
		.ea_clocks_in(ea_clocks_in), .ea_reads_in(ea_reads_in), .ea_writes_in(ea_writes_in),
		.wait_clocks_in(use_mem ? mem_wait : 8'h00), .clocks_out(clocks_out),
		.reads_out(reads_out), .writes_out(writes_out), .busy_out(busy_out), .done_out(done_out));
	task results;
		begin
			if (err_count == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] c, input [5:0] rd, input [5:0] w);
		begin
			compares = compares + 1;
			if (clocks_out !== c || reads_out !== rd || writes_out !== w) begin
				err_count = err_count + 1;
				$display("wrong value timing expected %h/%h/%h seen %h/%h/%h", c, rd, w,
					clocks_out, reads_out, writes_out);
			end
		end
	endtask
	task wait_done;
		begin
			wk = 0;
			while (done_out !== 1'b1 && wk < 300) begin
				@(negedge clk_in);
				wk = wk + 1;
			end
			if (wk >= 300) begin
				err_count = err_count + 1;
				results;
			end
		end
	endtask
	task go;
		begin
			@(negedge clk_in) start_in = 1'b1;
			@(negedge clk_in) start_in = 1'b0;
			wait_done;
			compares = compares + 1;
			if (wk !== clocks_out - 1 || busy_out !== 1'b0) begin
				err_count = err_count + 1;
				$display("wrong value busy_cycles expected %0d seen %0d", clocks_out - 1, wk);
			end
		end
	endtask
	always @(posedge clk_in) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			results;
		end
	end
	initial begin
		r[0] = 52'h00_20_0_00_08_01_01; r[1] = 52'h01_20_0_00_0a_01_01;
		r[2] = 52'h03_20_0_00_04_01_00; r[3] = 52'h02_08_0_00_08_01_00;
		r[4] = 52'h01_18_0_00_0e_02_00; r[5] = 52'h03_08_0_00_06_01_00;
		r[6] = 52'h04_04_0_00_0a_02_00; r[7] = 52'h04_00_0_00_06_01_00;
		r[8] = 52'h04_02_0_00_0a_02_00; r[9] = 52'h05_00_0_00_0a_02_00;
		r[10] = 52'h06_00_0_00_12_02_02; r[11] = 52'h07_04_0_00_0a_02_00;
		r[12] = 52'h07_00_0_00_0a_02_00; r[13] = 52'h07_01_0_00_10_03_00;
		r[14] = 52'h0b_00_0_00_0c_01_02; r[15] = 52'h0c_00_0_03_18_06_00;
		r[16] = 52'h0d_08_0_02_18_02_04; r[17] = 52'h0d_00_0_1f_84_02_1f;
		r[18] = 52'h0e_08_0_00_16_04_00; r[19] = 52'h0f_00_0_00_12_02_01;
		r[20] = 52'h10_08_0_00_06_01_00; r[21] = 52'h11_20_0_00_12_03_01;
		r[22] = 52'h10_28_0_00_1e_05_02; r[23] = 52'h10_20_1_00_16_02_01;
		r[24] = 52'h11_20_2_00_1c_04_01; r[25] = 52'h10_20_3_00_1a_04_01;
		r[26] = 52'h12_20_0_00_0c_03_00; r[27] = 52'h13_00_0_00_06_01_00;
		r[28] = 52'h14_20_0_00_12_03_01;
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		chk(8'h00, 6'h00, 6'h00);
		for (i = 0; i < 29; i = i + 1) begin
			{op_in, fl, loop_in, reg_count_in} = {r[i][48:44], r[i][41:36], r[i][33:32], r[i][28:24]};
			go;
			chk(r[i][23:16], r[i][13:8], r[i][5:0]);
		end
		{op_in, fl, loop_in, reg_count_in} = {5'h01, 6'h20, 2'h0, 5'h00};
		{ea_clocks_in, ea_reads_in, ea_writes_in} = {8'h06, 6'h01, 6'h00};
		go;
		chk(8'h10, 6'h02, 6'h01);
		{op_in, fl} = {5'h02, 6'h08};
		go;
		chk(8'h08, 6'h01, 6'h00);
		{op_in, fl, index_long_in, ea_clocks_in, ea_reads_in} = {5'h09, 6'h00, 1'b1, 8'h00, 6'h00};
		go;
		chk(8'h10, 6'h02, 6'h02);
		{op_in, use_mem, mem_cycles} = {5'h08, 1'b1, 6'h02};
		go;
		chk(8'h0c, 6'h02, 6'h00);
		use_mem = 1'b0;
		// a start held high while busy is ignored, then taken on the done cycle
		start_in = 1'b1;
		@(negedge clk_in) op_in = 5'h0a;
		wait_done;
		chk(8'h08, 6'h02, 6'h00);
		@(negedge clk_in) start_in = 1'b0;
		wait_done;
		chk(8'h04, 6'h01, 6'h00);
		results;
	end
endmodule
